// *** design/commutation_angle_generator.sv ***
// Commutation angle generator with APB register access
//
// Summary of operation
// - One electrical cycle is counts_per_n_cycles / cycle_divisor counts.
// - counts_per_n_cycles holds 0 to 8,388,607 and resets to 1000.
// - inter_phase_angle is in 1/256-cycle units and resets to 85.
// - Successive phases are offset by inter_phase_angle (85/171, 64/192).
// - Without the loop, swapping the two angles reverses rotation.
// - The quadrature counter resolves four counts per encoder line.
// - cycle_divisor holds up to 255 and resets to 1.
`timescale 1ns/1ps
`include "commutation_angle_generator_map.svh"
module commutation_angle_generator
    import commutation_angle_pkg::*;
(
    input wire logic pclk, // APB clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [`CAG_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic quad_a, // Encoder channel A
    input wire logic quad_b, // Encoder channel B
    input wire logic [31:0] position_word, // Position word from a network node
    output commutation_angle_pkg::phase_angles_s phase_angles // Phase angles
);
    import commutation_angle_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [`CAG_COUNTS_W-1:0] counts_per_n_cycles, next_counts_per_n_cycles;
    logic [`CAG_DIVISOR_W-1:0] cycle_divisor, next_cycle_divisor;
    angle_t inter_phase_angle, next_inter_phase_angle;
    control_s control, next_control;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic wr_en, sense_mismatch, next_sense_mismatch;
    angle_t base_angle, next_base_angle;
    logic [31:0] pos_count, next_pos_count;

    function automatic logic is_mapped(input logic [`CAG_ADDR_W-1:0] a);
        is_mapped = (a == `CAG_OFS_COUNTS) || (a == `CAG_OFS_DIVISOR) ||
            (a == `CAG_OFS_PHASE_ANGLE) || (a == `CAG_OFS_CONTROL) ||
            (a == `CAG_OFS_STATUS) || (a == `CAG_OFS_ANGLES) ||
            (a == `CAG_OFS_POSITION);
    endfunction

    assign wr_en = psel && penable && pready && pwrite && is_mapped(paddr);

    always_comb begin
        next_counts_per_n_cycles = counts_per_n_cycles;
        next_cycle_divisor = cycle_divisor;
        next_inter_phase_angle = inter_phase_angle;
        next_control = control;
        next_prdata = prdata;
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !is_mapped(paddr);
        if (wr_en) begin
            unique case (paddr)
                `CAG_OFS_COUNTS: begin
                    next_counts_per_n_cycles =
                        pwdata[`CAG_COUNTS_W-1:0];
                end
                `CAG_OFS_DIVISOR: begin
                    next_cycle_divisor = pwdata[`CAG_DIVISOR_W-1:0];
                end
                `CAG_OFS_PHASE_ANGLE: begin
                    next_inter_phase_angle = pwdata[`CAG_ANGLE_W-1:0];
                end
                `CAG_OFS_CONTROL: begin
                    next_control = control_s'(pwdata[`CAG_CTL_W-1:0]);
                end
                default: begin
                end
            endcase
        end
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `CAG_OFS_COUNTS: next_prdata = {9'h000, counts_per_n_cycles};
                `CAG_OFS_DIVISOR: next_prdata = {24'h000000, cycle_divisor};
                `CAG_OFS_PHASE_ANGLE: next_prdata = {24'h000000,
                    inter_phase_angle};
                `CAG_OFS_CONTROL: next_prdata = {28'h0000000, control};
                `CAG_OFS_STATUS: next_prdata = {16'h0000, base_angle,
                    7'h00, sense_mismatch};
                `CAG_OFS_ANGLES: next_prdata = phase_angles;
                `CAG_OFS_POSITION: next_prdata = pos_count;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counts_per_n_cycles <= `CAG_COUNTS_RESET;
            cycle_divisor <= `CAG_DIVISOR_RESET;
            inter_phase_angle <= `CAG_PHASE_ANGLE_RESET;
            control <= control_s'(`CAG_CTL_RESET);
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            counts_per_n_cycles <= next_counts_per_n_cycles;
            cycle_divisor <= next_cycle_divisor;
            inter_phase_angle <= next_inter_phase_angle;
            control <= next_control;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Position tracking
    logic [1:0] quad_prev, next_quad_prev;
    step_e step;

    // Four edges per line: with word_feedback clear, every A/B transition is one count
    always_comb begin
        step = ST_IDLE;
        if (control.word_feedback) begin
            if ($signed(position_word) > $signed(pos_count)) begin
                step = ST_UP;
            end else if ($signed(position_word) < $signed(pos_count)) begin
                step = ST_DOWN;
            end
        end else begin
            unique case ({quad_prev, quad_a, quad_b})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: step = ST_UP;
                4'b0010, 4'b1011, 4'b1101, 4'b0100: step = ST_DOWN;
                default: step = ST_IDLE;
            endcase
        end
        next_quad_prev = {quad_a, quad_b};
        next_pos_count = pos_count;
        if (step == ST_UP) begin
            next_pos_count = pos_count + 32'h00000001;
        end else if (step == ST_DOWN) begin
            next_pos_count = pos_count - 32'h00000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_prev <= 2'b00;
            pos_count <= 32'h00000000;
        end else begin
            quad_prev <= next_quad_prev;
            pos_count <= next_pos_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Electrical angle
    // Accumulator holds position within the cycle in counts times divisor
    logic [`CAG_COUNTS_W-1:0] cycle_pos, next_cycle_pos;
    logic [`CAG_COUNTS_W:0] sum_up, sum_dn;

    function automatic angle_t cycle_fraction(
        input logic [`CAG_COUNTS_W-1:0] pos,
        input logic [`CAG_COUNTS_W-1:0] span
    );
        logic [`CAG_COUNTS_W:0] rem;
        angle_t q;
        rem = {1'b0, pos};
        q = 8'h00;
        for (int i = `CAG_ANGLE_W - 1; i >= 0; i--) begin
            rem = {rem[`CAG_COUNTS_W-1:0], 1'b0};
            if (rem >= {1'b0, span}) begin
                q[i] = 1'b1;
                rem = rem - {1'b0, span};
            end
        end
        cycle_fraction = q;
    endfunction

    always_comb begin
        sum_up = {1'b0, cycle_pos} + {16'h0000, cycle_divisor};
        sum_dn = {1'b0, cycle_pos} + {1'b0, counts_per_n_cycles} -
            {16'h0000, cycle_divisor};
        next_cycle_pos = cycle_pos;
        if (counts_per_n_cycles == 23'h000000) begin
            next_cycle_pos = 23'h000000;
        end else if (step == ST_UP) begin
            if (sum_up >= {1'b0, counts_per_n_cycles}) begin
                next_cycle_pos = sum_up[`CAG_COUNTS_W-1:0] -
                    counts_per_n_cycles;
            end else begin
                next_cycle_pos = sum_up[`CAG_COUNTS_W-1:0];
            end
        end else if (step == ST_DOWN) begin
            if (cycle_pos >= {15'h0000, cycle_divisor}) begin
                next_cycle_pos = cycle_pos - {15'h0000, cycle_divisor};
            end else begin
                next_cycle_pos = sum_dn[`CAG_COUNTS_W-1:0];
            end
        end
        next_base_angle = cycle_fraction(cycle_pos, counts_per_n_cycles);
        // Zero span would read as a full quotient
        if (counts_per_n_cycles == 23'h000000) begin
            next_base_angle = 8'h00;
        end
        // Sensor polarity check once the current loop is closed
        next_sense_mismatch = control.current_loop_select &&
            (control.sense_into
                ? (inter_phase_angle <= `CAG_HALF_CYCLE)
                : (inter_phase_angle >= `CAG_HALF_CYCLE));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_pos <= 23'h000000;
            base_angle <= 8'h00;
            sense_mismatch <= 1'b0;
        end else begin
            cycle_pos <= next_cycle_pos;
            base_angle <= next_base_angle;
            sense_mismatch <= next_sense_mismatch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase outputs
    phase_angles_s next_phase_angles;

    // Angle sign sets direction, so swapping values reverses rotation
    generate
        for (genvar k = 0; k < `CAG_PHASES; k++) begin : g_phase
            always_comb begin
                next_phase_angles.angle[k] = 8'h00;
                if (control.commutation_select) begin
                    next_phase_angles.angle[k] = base_angle +
                        8'(k) * inter_phase_angle;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_angles <= '0;
        end else begin
            phase_angles <= next_phase_angles;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cycle_step_up: assert property (
        step == ST_UP && counts_per_n_cycles != 23'h000000 &&
        ({1'b0, cycle_pos} + {16'h0000, cycle_divisor}) <
            {1'b0, counts_per_n_cycles}
        |=> cycle_pos == $past(cycle_pos) + {15'h0000, $past(cycle_divisor)})
        else $error("cycle position did not advance by divisor");

    a_counts_write: assert property (
        wr_en && paddr == `CAG_OFS_COUNTS
        |=> counts_per_n_cycles == $past(pwdata[22:0]))
        else $error("counts setting not written");

    a_angle_write: assert property (
        wr_en && paddr == `CAG_OFS_PHASE_ANGLE
        |=> inter_phase_angle == $past(pwdata[7:0]))
        else $error("inter-phase angle not written");

    a_phase_spacing: assert property (
        control.commutation_select && $stable(inter_phase_angle)
        |=> phase_angles.angle[2] - phase_angles.angle[1] ==
            $past(inter_phase_angle))
        else $error("phase spacing differs from inter-phase angle");

    a_sense_into: assert property (
        control.current_loop_select && control.sense_into &&
        inter_phase_angle < 8'h80 |=> sense_mismatch)
        else $error("mismatch not flagged for inward sensors");

    a_sense_out: assert property (
        control.current_loop_select && !control.sense_into &&
        inter_phase_angle > 8'h80 |=> sense_mismatch)
        else $error("mismatch not flagged for outward sensors");

    a_quad_edge: assert property (
        !control.word_feedback && quad_prev == 2'b00 &&
        {quad_a, quad_b} == 2'b01
        |=> pos_count == $past(pos_count) + 32'h00000001)
        else $error("quadrature edge not counted");

    a_divisor_write: assert property (
        wr_en && paddr == `CAG_OFS_DIVISOR
        |=> cycle_divisor == $past(pwdata[7:0]))
        else $error("cycle divisor not written");

    a_phase_zero: assert property (
        control.commutation_select |=> phase_angles.angle[0] ==
            $past(base_angle))
        else $error("phase zero does not follow base angle");

    a_ready_pulse: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready is not a one-cycle answer");
endmodule

// *** design/commutation_angle_generator_map.svh ***
// Register offsets, field positions and reset values of the angle generator
`ifndef COMMUTATION_ANGLE_GENERATOR_MAP_SVH
`define COMMUTATION_ANGLE_GENERATOR_MAP_SVH

`define CAG_ADDR_W 8
`define CAG_OFS_COUNTS 8'h00
`define CAG_OFS_DIVISOR 8'h04
`define CAG_OFS_PHASE_ANGLE 8'h08
`define CAG_OFS_CONTROL 8'h0c
`define CAG_OFS_STATUS 8'h10
`define CAG_OFS_ANGLES 8'h14
`define CAG_OFS_POSITION 8'h18

`define CAG_COUNTS_W 23
`define CAG_COUNTS_RESET 23'h0003e8
`define CAG_DIVISOR_W 8
`define CAG_DIVISOR_RESET 8'h01
`define CAG_ANGLE_W 8
`define CAG_PHASE_ANGLE_RESET 8'h55
`define CAG_HALF_CYCLE 8'h80
`define CAG_PHASES 4

`define CAG_CTL_COMMUTATE 0
`define CAG_CTL_CURRENT_LOOP 1
`define CAG_CTL_WORD_FEEDBACK 2
`define CAG_CTL_SENSE_INTO 3
`define CAG_CTL_W 4
`define CAG_CTL_RESET 4'h0

`define CAG_STS_MISMATCH 0
`define CAG_STS_BASE_LSB 8

`endif

// *** design/commutation_angle_pkg.sv ***
// Types shared by the commutation angle generator and its bench
package commutation_angle_pkg;
    `include "commutation_angle_generator_map.svh"

    typedef logic [`CAG_ANGLE_W-1:0] angle_t;

    typedef struct packed {
        logic sense_into;
        logic word_feedback;
        logic current_loop_select;
        logic commutation_select;
    } control_s;

    typedef struct packed {
        angle_t [`CAG_PHASES-1:0] angle;
    } phase_angles_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_UP = 2'b01,
        ST_DOWN = 2'b10
    } step_e;
endpackage

// *** dv/commutation_angle_generator_tb_top.sv ***
// Self-checking bench for the commutation angle generator
`timescale 1ns/1ps
`include "commutation_angle_generator_map.svh"
module commutation_angle_generator_tb_top;
    import commutation_angle_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`CAG_ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic quad_a;
    logic quad_b;
    logic [31:0] position_word = 32'h0;
    phase_angles_s phase_angles;
    step_e move = ST_IDLE;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    longint pos = 0;
    longint cnt = 1000;
    longint div = 1;

    always #5 pclk = ~pclk;

    commutation_angle_generator i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .quad_a(quad_a), .quad_b(quad_b),
        .position_word(position_word), .phase_angles(phase_angles));

    motor_encoder_model i_enc (.pclk(pclk), .presetn(presetn),
        .move(move), .quad_a(quad_a), .quad_b(quad_b));

    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            complete_run();
        end
    end

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        move <= ST_IDLE;
        position_word <= 32'h0;
        pos = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Each count is one quadrature transition
    task automatic step(input step_e dir, input int n, input bit slow);
        repeat (n) begin
            @(posedge pclk);
            move <= dir;
            if (slow) begin
                @(posedge pclk);
                move <= ST_IDLE;
            end
        end
        @(posedge pclk);
        move <= ST_IDLE;
        pos += (dir == ST_UP) ? n : -n;
    endtask

    function automatic logic [7:0] base_of();
        longint cp;
        cp = ((pos * div) % cnt + cnt) % cnt;
        return 8'(cp * 256 / cnt);
    endfunction

    function automatic logic [31:0] exp_ph(input logic [7:0] ang);
        logic [31:0] r;
        for (int k = 0; k < 4; k++) r[8*k +: 8] = base_of() + 8'(k) * ang;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd(`CAG_OFS_COUNTS, 32'd1000, "counts reset");
        rd(`CAG_OFS_DIVISOR, 32'd1, "divisor reset");
        rd(`CAG_OFS_PHASE_ANGLE, 32'd85, "angle reset");
        rd(`CAG_OFS_CONTROL, 32'h0, "control reset");
        chk("phases idle", 32'h0, phase_angles);
        wr(`CAG_OFS_COUNTS, 32'hffffffff);
        rd(`CAG_OFS_COUNTS, 32'h007fffff, "counts max");
        wr(`CAG_OFS_COUNTS, 32'h0);
        rd(`CAG_OFS_COUNTS, 32'h0, "counts zero");
        wr(`CAG_OFS_DIVISOR, 32'hffffffff);
        rd(`CAG_OFS_DIVISOR, 32'hff, "divisor max");
        apb(1'b1, 8'h40, 32'h1, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
    endtask

    task automatic t_quad;
        logic [7:0] angs [4] = '{8'd85, 8'd171, 8'd64, 8'd192};
        do_reset();
        cnt = 4096;
        div = 3;
        wr(`CAG_OFS_COUNTS, 32'd4096);
        wr(`CAG_OFS_DIVISOR, 32'd3);
        wr(`CAG_OFS_CONTROL, 32'h1);
        foreach (angs[i]) begin
            wr(`CAG_OFS_PHASE_ANGLE, {24'h0, angs[i]});
            step(ST_UP, 400, i[0]);
            repeat (6) @(posedge pclk);
            chk("phases up", exp_ph(angs[i]), phase_angles);
            rd(`CAG_OFS_STATUS, {16'h0, base_of(), 8'h0}, "base");
            step(ST_DOWN, 30, ~i[0]);
            repeat (6) @(posedge pclk);
            chk("phases down", exp_ph(angs[i]), phase_angles);
        end
        wr(`CAG_OFS_CONTROL, 32'h0);
        repeat (4) @(posedge pclk);
        chk("commutation off", 32'h0, phase_angles);
    endtask

    task automatic t_word;
        do_reset();
        cnt = 64000;
        div = 1;
        wr(`CAG_OFS_COUNTS, 32'd64000);
        wr(`CAG_OFS_CONTROL, 32'h5);
        position_word <= 32'd16000;
        pos = 16000;
        repeat (16010) @(posedge pclk);
        rd(`CAG_OFS_POSITION, 32'd16000, "word position");
        chk("word phases", exp_ph(8'd85), phase_angles);
        position_word <= 32'd15900;
        pos = 15900;
        repeat (110) @(posedge pclk);
        chk("word back", exp_ph(8'd85), phase_angles);
    endtask

    task automatic t_sense;
        logic [3:0] ctl [7] = '{4'hb, 4'hb, 4'hb, 4'h3, 4'h3, 4'h3, 4'h1};
        logic [7:0] ang [7] = '{8'd171, 8'd85, 8'd128, 8'd85, 8'd171,
                               8'd128, 8'd85};
        logic mis [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        do_reset();
        foreach (ctl[i]) begin
            wr(`CAG_OFS_CONTROL, {28'h0, ctl[i]});
            wr(`CAG_OFS_PHASE_ANGLE, {24'h0, ang[i]});
            rd(`CAG_OFS_STATUS, {31'h0, mis[i]}, "mismatch");
        end
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_quad();
        t_word();
        t_sense();
        complete_run();
    end
endmodule

// *** dv/motor_encoder_model.sv ***
// Encoder side of the motor: quadrature lines driven from step commands
`timescale 1ns/1ps
module motor_encoder_model
    import commutation_angle_pkg::*;
(
    input wire logic pclk, // Servo clock
    input wire logic presetn, // Async reset, active low
    input wire commutation_angle_pkg::step_e move, // One count per cycle
    output logic quad_a, // Encoder channel A
    output logic quad_b // Encoder channel B
);
    logic [1:0] ph;
    logic [1:0] next_ph;

    ////////////////////////////////////////////////////////////////////////
    // Gray sequence 00, 01, 11, 10 when moving up; lines hold when idle
    always_comb begin
        next_ph = ph;
        if (move == ST_UP) begin
            next_ph = ph + 2'h1;
        end else if (move == ST_DOWN) begin
            next_ph = ph - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 2'd0;
        end else begin
            ph <= next_ph;
        end
    end

    assign quad_a = ph[1];
    assign quad_b = ph[1] ^ ph[0];
endmodule
